// [bench/tb.sv]
/*
  Self-checking bench for the spare checksum pad register bank.
  Assumes the bank answers APB with zero wait states while clk_en is high.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import crc_pad_pkg::*;

  logic                              pclk;
  logic                              presetn;
  logic                              psel;
  logic                              penable;
  logic                              pwrite;
  logic [ADDR_W-1:0]                 paddr;
  logic [DATA_W-1:0]                 pwdata;
  logic [DATA_W-1:0]                 prdata;
  logic                              pready;
  logic                              pslverr;
  logic [NUM_REGS*REG_W-1:0]         crc_words;
  logic [DATA_W-1:0]                 rd;
  logic                              err;
  logic [REG_W-1:0]                  wval;
  logic                              clk_en;
  logic [3:0]                        pstrb;
  int                                stall = 0;
  int                                n_fail = 0;
  int                                n_checks = 0;
  int                                cycles = 0;

  crc_pad_regs dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crc_words(crc_words));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus tasks; request held until pready is seen high at a rising edge
  function automatic logic [ADDR_W-1:0] addr_of(input int i);
    return {IDX_W'(IDX_FIRST + i), 2'b00};
  endfunction : addr_of

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // a stalled access drops clock enable for a few edges
    if (stall > 0) begin
      clk_en <= 1'b0;
      repeat (stall) @(posedge pclk);
      clk_en <= 1'b1;
    end
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic test_done;
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // reset, then every word and its checksum view must show its reset value
  task automatic reset_check;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) begin
      apb(1'b0, addr_of(i), 32'h0);
      chk("reset read", {16'h0000, RSTVAL[i]}, rd);
      chk("reset crc", RSTVAL[i], crc_words[16*i +: 16]);
    end
  endtask : reset_check

  ////////////////////////////////////////////////////////////////////////////
  // hang guard: far more cycles than the whole sequence needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: reset values, masked write/read-back, unmapped, re-reset
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    clk_en = 1'b1;
    pstrb = 4'hF;
    reset_check();
    for (int p = 0; p < REG_W; p++) begin
      // per-word data, distinct for shifts 0 to 13, catches address aliasing between words
      for (int i = 0; i < NUM_REGS; i++)
        apb(1'b1, addr_of(i), {16'hFFFF, ~(REG_W'(i) << p)});
      for (int i = 0; i < NUM_REGS; i++) begin
        wval = ~(REG_W'(i) << p) & WMASK[i];
        apb(1'b0, addr_of(i), 32'h0);
        chk("read back", {16'h0000, wval}, rd);
        chk("mapped err", 32'(1'b0), 32'(err));
        chk("crc view", wval, crc_words[16*i +: 16]);
      end
    end
    // neighbours of the bank are not part of it and must not alias into it
    apb(1'b1, 12'h330, 32'hFFFF_FFFF);
    apb(1'b1, 12'h34C, 32'hFFFF_FFFF);
    apb(1'b0, 12'h34C, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped err", 32'(1'b1), 32'(err));
    apb(1'b0, addr_of(0), 32'h0);
    chk("cd unchanged", {16'h0000, ~16'h0000 & WMASK[0]}, rd);
    // single byte lanes under a stalled access; misaligned write dropped
    stall = 2;
    pstrb <= 4'h1;
    apb(1'b1, ADDR_CRC_PAD_WORD_CE, 32'h0000_A5C3);
    pstrb <= 4'h2;
    apb(1'b1, ADDR_CRC_PAD_WORD_CF, 32'h0000_1234);
    stall = 0;
    pstrb <= 4'hF;
    apb(1'b1, 12'h339, 32'h0000_0000);
    chk("misaligned err", 32'(1'b1), 32'(err));
    apb(1'b0, ADDR_CRC_PAD_WORD_CE, 32'h0);
    chk("ce low lane", 32'h0000_7FC3, rd);
    apb(1'b0, ADDR_CRC_PAD_WORD_CF, 32'h0);
    chk("cf high lane", 32'h0000_12FF, rd);
    reset_check();
    test_done();
  end

endmodule : tb

`default_nettype wire

// [core/crc_pad_regs.sv]
/*
  Spare checksum pad register bank behind an APB slave.
  Six 16-bit scratch words whose contents feed the section-3 checksum.
  Assumes pclk at 125 MHz, APB master on the same clock, checksum
  engine on the same clock reading crc_words.
*/
// Our own choice: the APB interface to the registers.
// How it works
// - every spare field is plain storage that reads back what was written and drives nothing but crc_words.
// - all six words are presented to the section 3 checksum engine on crc_words.
// - word CD keeps bits 15:8 reading zero and bits 7:0 as spare storage resetting to zero.
// - words CE and CF are full 16-bit spare storage resetting to zero.
// - words D0 to D2 hold spare bits 15:13 and 4:0 with bits 12:5 reading zero.
// - at reset D0 to D2 clear bits 15:13 and load 0, 1 and 2 into bits 4:0.
`timescale 1ns/1ps
`default_nettype none

module crc_pad_regs
  import crc_pad_pkg::*;
(
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic                                   clk_en,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [crc_pad_pkg::ADDR_W-1:0]         paddr,
  input  wire logic [crc_pad_pkg::DATA_W-1:0]         pwdata,
  input  wire logic [3:0]                             pstrb,
  output logic      [crc_pad_pkg::DATA_W-1:0]         prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  output logic [crc_pad_pkg::NUM_REGS*crc_pad_pkg::REG_W-1:0] crc_words
);
  import crc_pad_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  logic [REG_W-1:0]    word_r [NUM_REGS];
  logic [2:0]          slot;
  logic                hit;
  logic                setup;
  logic                access;
  logic                wr_take;
  logic [REG_W-1:0]    wr_data;
  logic                first_r;

  // slot of a byte address, or hit low when nothing is mapped there
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] off;
    idx = a[ADDR_W-1:2];
    off = idx - IDX_FIRST;
    if (a[1:0] == 2'h0 && idx >= IDX_FIRST && idx <= IDX_LAST) begin
      decode = {1'b1, off[2:0]};
    end else begin
      decode = 4'h0;
    end
  endfunction : decode

  assign {hit, slot} = decode(paddr);
  assign setup       = clk_en && psel && !penable;
  assign access      = clk_en && psel && penable;
  // zero wait state; a frozen clock enable stretches the access phase
  assign pready      = access;
  assign wr_take     = access && pwrite && hit;
  // strobes below 16 bits gate the two live byte lanes
  assign wr_data     = {pstrb[1] ? pwdata[15:8] : word_r[slot][15:8],
                        pstrb[0] ? pwdata[7:0]  : word_r[slot][7:0]};

  ////////////////////////////////////////////////////////////////////////
  // storage: only writable bits ever change, reserved ones stay zero

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        word_r[i] <= RSTVAL[i];
      end
    end else if (wr_take) begin
      word_r[slot] <= wr_data & WMASK[slot];
    end
  end

  // the checksum engine sees the stored words and nothing else
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      crc_words[i*REG_W +: REG_W] = word_r[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data and error, captured in the setup cycle

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      // unmapped addresses answer zero data with an error
      prdata  <= hit ? {16'h0000, word_r[slot]} : 32'h0000_0000;
      pslverr <= !hit;
    end
  end

  // marks the stretch from reset release to the first enabled edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_r <= 1'b1;
    end else if (clk_en) begin
      first_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  AST_WRITE_READBACK: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && pstrb[1:0] == 2'h3)
      |=> word_r[$past(slot)] == ($past(pwdata[15:0]) & WMASK[$past(slot)]))
    else $error("spare word did not take the written value");

  AST_HOLD_NO_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_take |=> $stable(crc_words))
    else $error("spare word changed without a write");

  AST_CRC_MIRROR: assert property (
    @(posedge pclk) disable iff (!presetn)
    crc_words[15:0] == word_r[0] && crc_words[95:80] == word_r[5])
    else $error("checksum view differs from stored words");

  AST_CD_UPPER_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    (word_r[0] & MASK_CD_RSVD) == 16'h0000)
    else $error("word CD upper byte not zero");

  AST_CE_FULL_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && paddr == ADDR_CRC_PAD_WORD_CE && pstrb[1:0] == 2'h3)
      ##1 1'b1 ##1 1'b1
      |-> crc_words[31:16] == $past(pwdata[15:0], 2))
    else $error("word CE not full-width storage");

  AST_D_RSVD_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((word_r[3] | word_r[4] | word_r[5]) & MASK_D_RSVD) == 16'h0000)
    else $error("reserved bits of D words not zero");

  AST_RESET_VALUES: assert property (
    @(posedge pclk) disable iff (!presetn)
    first_r |-> (word_r[3] == 16'h0000 && word_r[4] == 16'h0001 &&
                 word_r[5] == 16'h0002 && word_r[0] == 16'h0000))
    else $error("spare words wrong after reset");

  AST_RSVD_WRITE_IGNORED: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && paddr == ADDR_CRC_PAD_WORD_D1 && pstrb[1:0] == 2'h3)
      |=> crc_words[79:64] == ($past(pwdata[15:0]) & 16'hE01F))
    else $error("reserved bits took write data");

  AST_READ_RETURNS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && hit && !pwrite) |=> prdata == {16'h0000, word_r[$past(slot)]})
    else $error("read data does not match stored word");

  ////////////////////////////////////////////////////////////////////////
  // bus timing, clock enable and byte lane checks
  // each one watches a path that the read-back checks above miss
  // the clock enable is a freeze, so every stored bit must hold with it
  // low; a stalled master simply sees pready low for longer

  // a low clock enable must hold every stored word
  AST_FREEZE_WORDS: assert property (
    @(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(crc_words))
    else $error("spare word changed while clock enable low");

  // a low clock enable must hold the read answer too
  AST_FREEZE_READ: assert property (
    @(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(prdata) && $stable(pslverr))
    else $error("read answer changed while clock enable low");

  // no transfer completes while frozen
  AST_STALL_NO_READY: assert property (
    @(posedge pclk) disable iff (!presetn)
    !clk_en |-> !pready)
    else $error("ready raised while clock enable low");

  // enabled access phases finish at once
  AST_ZERO_WAIT: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && clk_en) |-> pready)
    else $error("access phase not answered at once");

  // ready only ever marks an enabled access phase
  AST_PREADY_ONLY_ACCESS: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |-> (psel && penable && clk_en))
    else $error("ready raised outside an access phase");

  // read answer stands until the next setup cycle
  AST_READ_STANDS: assert property (
    @(posedge pclk) disable iff (!presetn)
    !setup |=> $stable(prdata) && $stable(pslverr))
    else $error("read answer moved outside a setup cycle");

  // unmapped addresses answer zero with an error
  AST_UNMAPPED_ERR: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !hit) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // mapped addresses never raise the error
  AST_MAPPED_OK: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && hit) |=> !pslverr)
    else $error("mapped access raised an error");

  // the upper bus half carries no storage
  AST_PRDATA_UPPER: assert property (
    @(posedge pclk) disable iff (!presetn)
    prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  // a low lane write keeps the high byte
  AST_LOW_LANE_ONLY: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && pstrb[1:0] == 2'h1)
      |=> word_r[$past(slot)][15:8] == $past(word_r[slot][15:8]))
    else $error("low lane write touched the high byte");

  // a high lane write keeps the low byte
  AST_HIGH_LANE_ONLY: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && pstrb[1:0] == 2'h2)
      |=> word_r[$past(slot)][7:0] == $past(word_r[slot][7:0]))
    else $error("high lane write touched the low byte");

  // reads of word CD show a zero upper byte
  AST_CD_READ_UPPER: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && hit && slot == 3'h0) |=> prdata[15:8] == 8'h00)
    else $error("word CD read a non-zero upper byte");

  // a write to word CD never fills its upper byte
  AST_CD_UPPER_DROP: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && slot == 3'h0) |=> word_r[0][15:8] == 8'h00)
    else $error("word CD upper byte took write data");

  // reads of D words show zero reserved bits
  AST_D_READ_RSVD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && hit && slot >= 3'h3)
      |=> (prdata[15:0] & MASK_D_RSVD) == 16'h0000)
    else $error("D word read non-zero reserved bits");

  // full writes to D words land in both spare fields
  AST_D_SPARE_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && slot >= 3'h3 && pstrb[1:0] == 2'h3)
      |=> (word_r[$past(slot)] & MASK_D_SPARE) ==
          ($past(pwdata[15:0]) & MASK_D_SPARE))
    else $error("D word spare fields did not take the write");

  // a write to word CE leaves the other five words alone
  AST_CROSS_WORD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_take && slot == 3'h1) |=> crc_words[15:0] == $past(crc_words[15:0])
      && crc_words[95:32] == $past(crc_words[95:32]))
    else $error("write to word CE disturbed another word");

  // the checksum view agrees with what software reads
  AST_CRC_TRACKS_READ: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && hit && !pwrite)
      |=> prdata[15:0] == crc_words[$past(slot)*REG_W +: REG_W])
    else $error("checksum view differs from read data");

  // reads never change storage
  AST_NO_WRITE_ON_READ: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && !pwrite) |=> $stable(crc_words))
    else $error("spare word changed on a read");

  // misaligned writes are dropped
  AST_MISALIGNED_DROPPED: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr[1:0] != 2'h0) |=> $stable(crc_words))
    else $error("misaligned write changed a spare word");

  // words CE and CF come out of reset at zero
  AST_RESET_CE_CF: assert property (
    @(posedge pclk) disable iff (!presetn)
    first_r |-> (word_r[1] == RST_CRC_PAD_WORD_CE &&
                 word_r[2] == RST_CRC_PAD_WORD_CF))
    else $error("word CE or CF wrong after reset");

  // upper spare fields of the D words come out of reset at zero
  AST_D_UPPER_RESET: assert property (
    @(posedge pclk) disable iff (!presetn)
    first_r |-> ((word_r[3] | word_r[4] | word_r[5]) & 16'hE000) == 16'h0000)
    else $error("D word upper spare field wrong after reset");

endmodule : crc_pad_regs

`default_nettype wire

// [pkg/crc_pad_pkg.sv]
/*
  Constants for the spare checksum pad register bank: register indices,
  byte addresses, writable-bit masks and reset values.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package crc_pad_pkg;

  // bus widths
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int REG_W     = 16;
  localparam int NUM_REGS  = 6;
  localparam int IDX_W     = 10;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CRC_PAD_WORD_CD = 10'h0CD;
  localparam logic [IDX_W-1:0] IDX_CRC_PAD_WORD_CE = 10'h0CE;
  localparam logic [IDX_W-1:0] IDX_CRC_PAD_WORD_CF = 10'h0CF;
  localparam logic [IDX_W-1:0] IDX_CRC_PAD_WORD_D0 = 10'h0D0;
  localparam logic [IDX_W-1:0] IDX_CRC_PAD_WORD_D1 = 10'h0D1;
  localparam logic [IDX_W-1:0] IDX_CRC_PAD_WORD_D2 = 10'h0D2;
  localparam logic [IDX_W-1:0] IDX_FIRST           = IDX_CRC_PAD_WORD_CD;
  localparam logic [IDX_W-1:0] IDX_LAST            = IDX_CRC_PAD_WORD_D2;

  // byte addresses on the APB
  localparam logic [ADDR_W-1:0] ADDR_CRC_PAD_WORD_CD = 12'h334;
  localparam logic [ADDR_W-1:0] ADDR_CRC_PAD_WORD_CE = 12'h338;
  localparam logic [ADDR_W-1:0] ADDR_CRC_PAD_WORD_CF = 12'h33C;
  localparam logic [ADDR_W-1:0] ADDR_CRC_PAD_WORD_D0 = 12'h340;
  localparam logic [ADDR_W-1:0] ADDR_CRC_PAD_WORD_D1 = 12'h344;
  localparam logic [ADDR_W-1:0] ADDR_CRC_PAD_WORD_D2 = 12'h348;

  // field layouts
  localparam logic [REG_W-1:0] MASK_CD_SPARE  = 16'h00FF; // 7:0
  localparam logic [REG_W-1:0] MASK_FULL      = 16'hFFFF; // 15:0
  localparam logic [REG_W-1:0] MASK_D_SPARE   = 16'hE01F; // 15:13, 4:0
  localparam logic [REG_W-1:0] MASK_D_RSVD    = 16'h1FE0; // 12:5
  localparam logic [REG_W-1:0] MASK_CD_RSVD   = 16'hFF00; // 15:8

  // writable bits per slot, slot 0 is the word at index CD
  localparam logic [NUM_REGS-1:0][REG_W-1:0] WMASK = {
    MASK_D_SPARE, MASK_D_SPARE, MASK_D_SPARE,
    MASK_FULL, MASK_FULL, MASK_CD_SPARE};

  // reset values
  localparam logic [REG_W-1:0] RST_CRC_PAD_WORD_CD = 16'h0000;
  localparam logic [REG_W-1:0] RST_CRC_PAD_WORD_CE = 16'h0000;
  localparam logic [REG_W-1:0] RST_CRC_PAD_WORD_CF = 16'h0000;
  localparam logic [REG_W-1:0] RST_CRC_PAD_WORD_D0 = 16'h0000;
  localparam logic [REG_W-1:0] RST_CRC_PAD_WORD_D1 = 16'h0001;
  localparam logic [REG_W-1:0] RST_CRC_PAD_WORD_D2 = 16'h0002;
  localparam logic [NUM_REGS-1:0][REG_W-1:0] RSTVAL = {
    RST_CRC_PAD_WORD_D2, RST_CRC_PAD_WORD_D1, RST_CRC_PAD_WORD_D0,
    RST_CRC_PAD_WORD_CF, RST_CRC_PAD_WORD_CE, RST_CRC_PAD_WORD_CD};

endpackage : crc_pad_pkg
